// File: rtl/tfc_pkg.sv
// package for the trace feature and ownership-tag register slice
// assumes a single 100 MHz register clock shared by every user of the package
package tfc_pkg;
  localparam int TFC_AW = 12;
  localparam int TFC_DW = 32;
  localparam int TFC_TAGS = 4;

  // register byte offsets, one aligned word each
  localparam logic [11:0] TFC_OFS_FEAT2 = 12'h000;
  localparam logic [11:0] TFC_OFS_FEAT3 = 12'h004;
  localparam logic [11:0] TFC_OFS_ITCTRL = 12'h008;
  localparam logic [11:0] TFC_OFS_TAGSET = 12'h00c;
  localparam logic [11:0] TFC_OFS_TAGCLR = 12'h010;

  // field positions
  localparam int TFC_COMP_LSB = 4;
  localparam int TFC_TRIG_LSB = 0;
  localparam int TFC_MAST_LSB = 0;
  localparam int TFC_IME_BIT = 0;

  // feature encodings
  localparam logic [1:0] TFC_COMP_UNDEF = 2'h0;
  localparam logic [1:0] TFC_COMP_NONE = 2'h1;
  localparam logic [1:0] TFC_COMP_ALWAYS = 2'h2;
  localparam logic [1:0] TFC_COMP_PROG = 2'h3;
  localparam logic [1:0] TFC_TRIG_UNDEF = 2'h0;
  localparam logic [1:0] TFC_TRIG_ABSENT = 2'h1;
  localparam logic [1:0] TFC_TRIG_PRESENT = 2'h2;

  // values after reset, the implemented-tag mask and the zero word
  localparam logic TFC_IME_RESET = 1'b0;
  localparam logic [TFC_TAGS-1:0] TFC_TAGS_RESET = 4'h0;
  localparam logic [TFC_TAGS-1:0] TFC_TAGS_IMPL = 4'hf;
  localparam logic [31:0] TFC_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [TFC_AW-1:0] addr;
    logic [TFC_DW-1:0] wdata;
  } tfc_req_t;

  typedef struct packed {
    logic valid;
    logic [TFC_DW-1:0] rdata;
  } tfc_rsp_t;

  typedef enum logic [2:0] {
    TFC_SEL_NONE,
    TFC_SEL_FEAT2,
    TFC_SEL_FEAT3,
    TFC_SEL_ITCTRL,
    TFC_SEL_TAGSET,
    TFC_SEL_TAGCLR
  } tfc_sel_t;
endpackage

// File: rtl/tfc_regs.sv
// feature, integration-mode and ownership-tag registers of the trace unit
// assumes a one-request-per-cycle register port; the answer follows one cycle later
`timescale 1ns/10ps
// Contract
// R01 - compression field reports 00 undefined, 01 none, 10 always, 11 programmable.
// R02 - trigger-enable register field reports 00 unindicated, 01 absent, 10 present.
// R03 - unlisted feature encodings are reserved and never reported.
// R04 - third feature word low half holds master count minus one; upper half zero.
// R05 - integration control bit 0 selects integration mode, resets to zero.
// R06 - software sets integration mode only while tracing is disabled.
// R07 - integration control present: writing one reads back one.
// R08 - ownership tags never block or alter access to other registers.
// R09 - at least four ownership tag bits are implemented.
// R10 - agent sets its tag, reads status, keeps ownership only if alone.
// R11 - tag-set read returns ones for implemented tags, zero above.
// R12 - writing ones to tag-set sets those tags.
// R13 - tag-clear read shows tags; writing ones clears those tags.
// R14 - reset clears every ownership tag.
// R15 - zeros and unimplemented positions leave tags unchanged.
// R16 - feature words are read-only constants; writes do nothing.
module tfc_regs
  import tfc_pkg::*;
#(
  parameter logic [1:0] COMPRESSION_SUPPORT = TFC_COMP_PROG,
  parameter logic [1:0] TRIGGER_ENABLE_REG_SUPPORT = TFC_TRIG_PRESENT,
  parameter logic [15:0] MASTER_COUNT_MINUS_ONE = 16'h0000
) (
  input wire logic clk,
  input wire logic reset,
  input wire tfc_req_t req,
  output tfc_rsp_t rsp_q,
  output logic integration_mode_q,
  output logic [TFC_TAGS-1:0] tags_q
);
  // a reserved trigger-field code would mislead probing software; fall back to undefined
  function automatic logic [1:0] trig_legal(input logic [1:0] code);
    trig_legal = (code == 2'h3) ? TFC_TRIG_UNDEF : code; // R03
  endfunction

  function automatic tfc_sel_t decode(input logic [TFC_AW-1:0] addr);
    case (addr)
      TFC_OFS_FEAT2: decode = TFC_SEL_FEAT2;
      TFC_OFS_FEAT3: decode = TFC_SEL_FEAT3;
      TFC_OFS_ITCTRL: decode = TFC_SEL_ITCTRL;
      TFC_OFS_TAGSET: decode = TFC_SEL_TAGSET;
      TFC_OFS_TAGCLR: decode = TFC_SEL_TAGCLR;
      default: decode = TFC_SEL_NONE;
    endcase
  endfunction

  logic [TFC_DW-1:0] feat2_word;
  logic [TFC_DW-1:0] feat3_word;
  tfc_sel_t sel;
  logic wr;
  logic tag_set_en;
  logic tag_clr_en;
  logic ime_d;
  tfc_rsp_t rsp_d;

  always_comb begin
    feat2_word = TFC_ZERO;
    feat2_word[TFC_COMP_LSB +: 2] = COMPRESSION_SUPPORT; // R01
    feat2_word[TFC_TRIG_LSB +: 2] = trig_legal(TRIGGER_ENABLE_REG_SUPPORT); // R02 R03
    feat3_word = TFC_ZERO;
    feat3_word[TFC_MAST_LSB +: 16] = MASTER_COUNT_MINUS_ONE; // R04
  end

  assign sel = decode(req.addr);
  assign wr = req.valid && req.write;
  // tags are only strobed by their own decodes, so no other access sees them
  assign tag_set_en = wr && (sel == TFC_SEL_TAGSET); // R08
  assign tag_clr_en = wr && (sel == TFC_SEL_TAGCLR); // R08

  tfc_tag_bank u_tags (
    .clk(clk),
    .reset(reset),
    .set_en(tag_set_en),
    .clr_en(tag_clr_en),
    .mask(req.wdata[TFC_TAGS-1:0]),
    .tags_q(tags_q)
  );

  always_comb begin
    ime_d = integration_mode_q;
    if (wr && (sel == TFC_SEL_ITCTRL)) begin
      ime_d = req.wdata[TFC_IME_BIT]; // R05 R07
    end
  end

  always_comb begin
    rsp_d.valid = req.valid;
    rsp_d.rdata = TFC_ZERO;
    if (req.valid && !req.write) begin
      case (sel)
        TFC_SEL_FEAT2: rsp_d.rdata = feat2_word; // R16
        TFC_SEL_FEAT3: rsp_d.rdata = feat3_word; // R16
        TFC_SEL_ITCTRL: rsp_d.rdata[TFC_IME_BIT] = integration_mode_q; // R07
        TFC_SEL_TAGSET: rsp_d.rdata[TFC_TAGS-1:0] = TFC_TAGS_IMPL; // R11 R09
        TFC_SEL_TAGCLR: rsp_d.rdata[TFC_TAGS-1:0] = tags_q; // R13
        default: rsp_d.rdata = TFC_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      integration_mode_q <= TFC_IME_RESET; // R05
      rsp_q <= '0;
    end else begin
      integration_mode_q <= ime_d;
      rsp_q <= rsp_d;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [TFC_AW-1:0] rd_addr_q;
  logic rd_q;
  logic [TFC_TAGS-1:0] tags_prev_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_addr_q <= '0;
      rd_q <= 1'b0;
      tags_prev_q <= TFC_TAGS_RESET;
    end else begin
      rd_addr_q <= req.addr;
      rd_q <= req.valid && !req.write;
      tags_prev_q <= tags_q;
    end
  end

  // feature words: the constant fields and the reserved zeros around them, except bit 2 of the second feature word

  comp_field_a: assert property (rd_q && rd_addr_q == TFC_OFS_FEAT2 |->
    rsp_q.rdata[TFC_COMP_LSB +: 2] == COMPRESSION_SUPPORT && rsp_q.rdata[3] == 1'b0)
    else $error("compression field wrong"); // R01

  trig_field_a: assert property (rd_q && rd_addr_q == TFC_OFS_FEAT2 |->
    rsp_q.rdata[1:0] != 2'h3 && rsp_q.rdata[31:6] == 26'h0)
    else $error("trigger field reserved code"); // R02 R03

  master_count_a: assert property (rd_q && rd_addr_q == TFC_OFS_FEAT3 |->
    rsp_q.rdata == {16'h0000, MASTER_COUNT_MINUS_ONE})
    else $error("master count word wrong"); // R04

  feat_const_a: assert property (wr && sel == TFC_SEL_FEAT2 |=> $stable(integration_mode_q)
    && $stable(tags_q))
    else $error("feature write had an effect"); // R16

  feat3_const_a: assert property (wr && sel == TFC_SEL_FEAT3 |=> $stable(integration_mode_q)
    && $stable(tags_q))
    else $error("feature three write had an effect"); // R16

  // integration mode: written value lands, nothing else moves it

  ime_readback_a: assert property (wr && sel == TFC_SEL_ITCTRL && req.wdata[0] ##1
    req.valid && !req.write && sel == TFC_SEL_ITCTRL |-> ##1 rsp_q.rdata == 32'h0000_0001)
    else $error("integration bit not read back"); // R07 R05

  ime_write_a: assert property (wr && sel == TFC_SEL_ITCTRL |=>
    integration_mode_q == $past(req.wdata[TFC_IME_BIT]))
    else $error("integration bit write lost"); // R05 R07

  ime_hold_a: assert property (!(wr && sel == TFC_SEL_ITCTRL) |=>
    $stable(integration_mode_q))
    else $error("integration bit moved without a write"); // R05

  ime_reserved_a: assert property (rd_q && rd_addr_q == TFC_OFS_ITCTRL |->
    rsp_q.rdata[31:1] == 31'h0)
    else $error("integration reserved bits not zero"); // R05

  // ownership tags: set and clear by mask, status read, nothing else touches them

  tag_impl_a: assert property (rd_q && rd_addr_q == TFC_OFS_TAGSET |->
    rsp_q.rdata == 32'h0000_000f)
    else $error("tag-set read not all ones"); // R11 R09

  tag_set_a: assert property (tag_set_en |=>
    tags_q == (tags_prev_q | $past(req.wdata[TFC_TAGS-1:0])))
    else $error("tag set wrong"); // R12 R15

  tag_clr_a: assert property (tag_clr_en |=>
    tags_q == (tags_prev_q & ~$past(req.wdata[TFC_TAGS-1:0])))
    else $error("tag clear wrong"); // R13 R15

  // the status read shows the tags as they stood when the read was taken
  tag_status_a: assert property (rd_q && rd_addr_q == TFC_OFS_TAGCLR |->
    rsp_q.rdata == {28'h0, tags_prev_q})
    else $error("tag status read wrong"); // R13

  tag_stable_a: assert property (!tag_set_en && !tag_clr_en |=> $stable(tags_q))
    else $error("tags moved without a tag write"); // R08

  // register port: one answer per request, quiet otherwise

  answer_a: assert property (req.valid |=> rsp_q.valid)
    else $error("no answer one cycle after request"); // R08

  idle_quiet_a: assert property (!req.valid |=> !rsp_q.valid)
    else $error("answer without a request"); // R08

  write_zero_a: assert property (wr |=> rsp_q.rdata == TFC_ZERO)
    else $error("write answer carried data"); // R08

  // unmapped reads return zero so probing software sees an empty slot
  unmapped_zero_a: assert property (rd_q && decode(rd_addr_q) == TFC_SEL_NONE |->
    rsp_q.rdata == TFC_ZERO)
    else $error("unmapped read not zero"); // R08

  set_then_status_c: cover property (tag_set_en ##1 req.valid && !req.write
    && sel == TFC_SEL_TAGCLR);
  contention_c: cover property (tag_set_en ##[1:4] tag_set_en ##1 tags_q != tags_prev_q);
  ime_on_c: cover property ($rose(integration_mode_q));
  ime_probe_c: cover property (wr && sel == TFC_SEL_ITCTRL && req.wdata[0] ##1
    req.valid && !req.write && sel == TFC_SEL_ITCTRL);
  tag_release_c: cover property (tag_clr_en ##1 tags_q == TFC_TAGS_RESET);
endmodule

// File: rtl/tfc_tag_bank.sv
// ownership tag bits: write-one-to-set and write-one-to-clear
// assumes set and clear strobes come from distinct register decodes
`timescale 1ns/10ps
module tfc_tag_bank
  import tfc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic set_en,
  input wire logic clr_en,
  input wire logic [TFC_TAGS-1:0] mask,
  output logic [TFC_TAGS-1:0] tags_q
);
  logic [TFC_TAGS-1:0] tags_d;

  always_comb begin
    tags_d = tags_q;
    if (set_en) begin
      tags_d = tags_q | mask; // R12 R15
    end else if (clr_en) begin
      tags_d = tags_q & ~mask; // R13 R15
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tags_q <= TFC_TAGS_RESET; // R14
    end else begin
      tags_q <= tags_d;
    end
  end
endmodule

// File: test/tfc_regs_test.sv
// self-checking bench for the feature, integration-mode and ownership-tag registers
// assumes the one-cycle answer of the register port and an async active-high reset
`timescale 1ns/10ps
module tfc_regs_test
  import tfc_pkg::*;
;
  localparam logic [31:0] FEAT2 = {26'h0, TFC_COMP_PROG, 2'h0, TFC_TRIG_PRESENT};
  localparam logic [31:0] FEAT3 = 32'h0000_0007;
  logic clk;
  logic reset;
  tfc_req_t req;
  tfc_rsp_t rsp_q;
  logic integration_mode_q;
  logic [TFC_TAGS-1:0] tags_q;
  int n_errors;
  int compares;
  logic [31:0] rd;

  tfc_regs #(
    .COMPRESSION_SUPPORT(TFC_COMP_PROG),
    .TRIGGER_ENABLE_REG_SUPPORT(TFC_TRIG_PRESENT),
    .MASTER_COUNT_MINUS_ONE(16'h0007)
  ) tfc_regs_inst (
    .clk(clk),
    .reset(reset),
    .req(req),
    .rsp_q(rsp_q),
    .integration_mode_q(integration_mode_q),
    .tags_q(tags_q)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // the answer stands for one cycle only, so it is sampled just after the taking edge
  task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    @(posedge clk);
    req <= {1'b1, wr, addr, wd};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    check({31'h0, rsp_q.valid}, 32'h1);
    rd = rsp_q.rdata;
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
    access(1'b0, addr, 32'h0);
    check(rd, exp);
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard: the whole run needs far fewer cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial begin
    reset = 1'b1;
    req = '0;
    n_errors = 0;
    compares = 0;
    rd = 32'h0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    #1;
    check({27'h0, integration_mode_q, tags_q}, 32'h0);
    rd_chk(TFC_OFS_FEAT2, FEAT2);
    rd_chk(TFC_OFS_FEAT3, FEAT3);
    access(1'b1, TFC_OFS_FEAT2, 32'hffff_ffff);
    access(1'b1, TFC_OFS_FEAT3, 32'h0000_0000);
    rd_chk(TFC_OFS_FEAT2, FEAT2);
    rd_chk(TFC_OFS_FEAT3, FEAT3);
    rd_chk(12'h100, 32'h0);
    $display("test features done");
    rd_chk(TFC_OFS_ITCTRL, 32'h0);
    // tracing is never enabled here, so setting integration mode is allowed
    access(1'b1, TFC_OFS_ITCTRL, 32'hffff_ffff);
    check({31'h0, integration_mode_q}, 32'h1);
    rd_chk(TFC_OFS_ITCTRL, 32'h1);
    access(1'b1, TFC_OFS_ITCTRL, 32'h0);
    rd_chk(TFC_OFS_ITCTRL, 32'h0);
    $display("test integration done");
    rd_chk(TFC_OFS_TAGSET, 32'h0000_000f);
    access(1'b1, TFC_OFS_TAGSET, 32'h1);
    access(1'b1, TFC_OFS_TAGSET, 32'hffff_fff4);
    rd_chk(TFC_OFS_TAGCLR, 32'h5);
    // a second agent sets its bit, sees others and backs off
    access(1'b1, TFC_OFS_TAGSET, 32'h2);
    rd_chk(TFC_OFS_TAGCLR, 32'h7);
    access(1'b1, TFC_OFS_TAGCLR, 32'hffff_fff2);
    rd_chk(TFC_OFS_TAGCLR, 32'h5);
    rd_chk(TFC_OFS_TAGSET, 32'h0000_000f);
    rd_chk(TFC_OFS_FEAT3, FEAT3);
    access(1'b1, TFC_OFS_ITCTRL, 32'h1);
    rd_chk(TFC_OFS_ITCTRL, 32'h1);
    access(1'b1, TFC_OFS_TAGCLR, 32'h1);
    check({28'h0, tags_q}, 32'h4);
    $display("test claim done");
    @(posedge clk);
    req <= {1'b1, 1'b1, TFC_OFS_TAGSET, 32'h8};
    @(posedge clk);
    req <= {1'b1, 1'b0, TFC_OFS_TAGCLR, 32'h0};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    check({31'h0, rsp_q.valid}, 32'h1);
    check(rsp_q.rdata, 32'hc);
    access(1'b1, TFC_OFS_ITCTRL, 32'h0);
    @(posedge clk);
    req <= {1'b1, 1'b1, TFC_OFS_ITCTRL, 32'h1};
    @(posedge clk);
    req <= {1'b1, 1'b0, TFC_OFS_ITCTRL, 32'h0};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    check(rsp_q.rdata, 32'h1);
    $display("test back to back done");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({27'h0, integration_mode_q, tags_q}, 32'h0);
    @(posedge clk);
    reset <= 1'b0;
    rd_chk(TFC_OFS_TAGCLR, 32'h0);
    rd_chk(TFC_OFS_ITCTRL, 32'h0);
    $display("test mid reset done");
    summarize();
  end
endmodule
